// *** rfsw_ctrl.sv ***
// rfsw_ctrl: host-side controller driving a latching multiport rf switch
// assumes drive pins are buffered outside (ground-drive inverts, logic-level not)
// assumes indicator inputs are already synchronous to clk_sys and high = closed
//
// Functional notes
// R1 - one asserted drive closes path, opens others
// R2 - switch breaks before it makes
// R3 - unselected paths terminated, solenoid current removed
// R4 - switch cuts drive current after latching
// R5 - drive pulses last at least 15 ms
// R6 - ground-drive variant: pull low selects
// R7 - logic-level variant: drive high selects
// R8 - deassert unwanted drives before new select
// R9 - drop all drives, then assert open-all
// R10 - solder variant has no open-all
// R11 - make-before-break: overlap 15 ms, drop old
// R12 - both paths close, old opens alone
// R13 - each closed path shows its indicator
// R14 - indicators follow real mechanical position
// R15 - four-throw leaves positions 1, 4 unused
// R16 - reset idles drives; verify indicators after command
`timescale 1ns/1ns
module rfsw_ctrl
  import rfsw_pkg::*;
#(
  parameter int unsigned LATCH_CYCLES       = LATCH_CYC,
  parameter bit          LOGIC_LEVEL_DRIVE  = 1'b1,
  parameter bit          SIX_THROW_CONFIG   = 1'b1,
  parameter bit          HAS_OPEN_ALL       = 1'b1,
  parameter bit          HOLD_DRIVE         = 1'b0
) (
  // clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ce,
  // command port
  input  wire logic              cmd_valid,
  input  wire rfsw_cmd_e         cmd_op,
  input  wire logic [PATH_W-1:0] cmd_path,
  output logic                   cmd_ready,
  output logic                   cmd_done,
  output logic                   cmd_fault,
  // switch pins
  output logic [NPATH-1:0]       drive_pin,
  output logic                   open_all_pin,
  input  wire logic [NPATH-1:0]  ind_closed
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam logic [5:0] VALID_MASK = SIX_THROW_CONFIG ? SIX_MASK : FOUR_MASK;  // [R15]

  rfsw_s       r;
  rfsw_s       next_r;
  rfsw_tmr_if  tif ();
  logic [5:0]  sel_onehot;
  logic        path_ok;
  logic [5:0]  pin_level;

  rfsw_latch_tmr #(
    .CYCLES (LATCH_CYCLES)
  ) u_tmr (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .tmr     (tif.tmr)
  );

  assign tif.start  = r.tmr_go;
  assign sel_onehot = (cmd_path < PATH_W'(NPATH)) ? (ONE_PATH << cmd_path) : NO_PATHS;
  assign path_ok    = |(sel_onehot & VALID_MASK);  // [R15]

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.done   = 1'b0;
    next_r.tmr_go = 1'b0;
    unique case (r.state)
      RFSW_IDLE: begin
        if (cmd_valid) begin
          next_r.busy  = 1'b1;
          next_r.fault = 1'b0;
          unique case (cmd_op)
            RFSW_CMD_SELECT: begin
              if (path_ok) begin
                next_r.want  = sel_onehot;
                next_r.drive = NO_PATHS;  // [R8] drop unwanted drives first
                next_r.state = RFSW_RELEASE;
              end else begin
                next_r.fault = 1'b1;
                next_r.done  = 1'b1;
                next_r.busy  = 1'b0;
              end
            end
            RFSW_CMD_MBB: begin
              if (path_ok && (r.drive != NO_PATHS || r.old_sel != NO_PATHS)) begin
                next_r.want    = sel_onehot;
                next_r.drive   = r.old_sel | sel_onehot;  // [R11] old and new together
                next_r.tmr_go  = 1'b1;
                next_r.state   = RFSW_OVERLAP;
              end else begin
                next_r.fault = 1'b1;
                next_r.done  = 1'b1;
                next_r.busy  = 1'b0;
              end
            end
            RFSW_CMD_OPEN_ALL: begin
              if (HAS_OPEN_ALL) begin  // [R10]
                next_r.want  = NO_PATHS;
                next_r.drive = NO_PATHS;  // [R9] drives off before open-all
                next_r.state = RFSW_RELEASE;
              end else begin
                next_r.fault = 1'b1;
                next_r.done  = 1'b1;
                next_r.busy  = 1'b0;
              end
            end
            default: begin
              next_r.fault = 1'b1;
              next_r.done  = 1'b1;
              next_r.busy  = 1'b0;
            end
          endcase
        end
      end
      // one clean cycle with every drive low avoids two engaged paths
      RFSW_RELEASE: begin
        next_r.tmr_go = 1'b1;
        if (r.want == NO_PATHS) begin
          next_r.open_all = 1'b1;  // [R9]
          next_r.state    = RFSW_OPEN;
        end else begin
          next_r.drive = r.want;  // [R1] [R2]
          next_r.state = RFSW_DRIVE;
        end
      end
      RFSW_DRIVE: begin
        if (tif.expired) begin  // [R5] held at least the latch time
          if (!HOLD_DRIVE) begin
            next_r.drive = NO_PATHS;  // [R4] switch latched, pulse may end
          end
          next_r.old_sel = r.want;
          next_r.state   = RFSW_CHECK;
        end
      end
      RFSW_OVERLAP: begin
        if (tif.expired) begin  // [R11] new path closed after 15 ms
          next_r.drive  = r.want;  // [R11] [R12] only the old drive is dropped
          next_r.tmr_go = 1'b1;
          next_r.state  = RFSW_DROP_OLD;
        end
      end
      // dropping both drives at once would leave both paths latched closed
      RFSW_DROP_OLD: begin
        if (tif.expired) begin
          if (!HOLD_DRIVE) begin
            next_r.drive = NO_PATHS;  // [R4] old path opened, pulse may end
          end
          next_r.old_sel = r.want;
          next_r.state   = RFSW_CHECK;
        end
      end
      RFSW_OPEN: begin
        if (tif.expired) begin  // [R5]
          next_r.open_all = 1'b0;
          next_r.old_sel  = NO_PATHS;
          next_r.state    = RFSW_CHECK;
        end
      end
      RFSW_CHECK: begin
        // indicators reflect real position, so mismatch means a stuck path
        next_r.fault = ((ind_closed & VALID_MASK) != r.want);  // [R13] [R14] [R16]
        next_r.done  = 1'b1;
        next_r.busy  = 1'b0;
        next_r.state = RFSW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '{state: RFSW_IDLE, default: '0};  // [R16]
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // pin polarity
  // ----------------------------------------------------------------
  // ground-drive buffer outside inverts; a released pin floats to deselected
  assign pin_level = LOGIC_LEVEL_DRIVE ? next_r.drive : ~next_r.drive;  // [R6] [R7]

  logic [NPATH-1:0] drive_q;
  logic             open_q;
  logic             ready_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drive_q <= LOGIC_LEVEL_DRIVE ? NO_PATHS : SIX_MASK;
      open_q  <= ~LOGIC_LEVEL_DRIVE;
      ready_q <= 1'b0;
    end else if (ce) begin
      drive_q <= pin_level;
      open_q  <= LOGIC_LEVEL_DRIVE ? next_r.open_all : ~next_r.open_all;  // [R9]
      ready_q <= (next_r.state == RFSW_IDLE);
    end
  end

  assign drive_pin    = drive_q;
  assign open_all_pin = open_q;
  assign cmd_ready    = ready_q;
  assign cmd_done     = r.done;
  assign cmd_fault    = r.fault;

endmodule : rfsw_ctrl

// *** rfsw_ctrl_props.sv ***
// rfsw_ctrl_props: port checks of the switch controller
// assumes pulsed drive; pins are judged at their select level, either polarity
`timescale 1ns/1ns
module rfsw_ctrl_props
  import rfsw_pkg::*;
#(
  parameter int unsigned LATCH_CYCLES      = LATCH_CYC,
  parameter bit          LOGIC_LEVEL_DRIVE = 1'b1,
  parameter bit          SIX_THROW_CONFIG  = 1'b1
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // command side
  input wire logic              ce,
  input wire logic              cmd_valid,
  input wire rfsw_cmd_e         cmd_op,
  input wire logic [PATH_W-1:0] cmd_path,
  input wire logic              cmd_ready,
  // switch pins
  input wire logic [NPATH-1:0]  drive_pin,
  input wire logic              open_all_pin
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // --------------------------------
  // helpers
  // --------------------------------
  // pins seen at their select level, so one set of checks fits both polarities
  localparam logic [5:0] VMASK = SIX_THROW_CONFIG ? SIX_MASK : FOUR_MASK;
  logic [NPATH-1:0] sel;
  logic             opn;
  logic [31:0]      ovl_cnt;
  assign sel = LOGIC_LEVEL_DRIVE ? drive_pin : ~drive_pin;
  assign opn = LOGIC_LEVEL_DRIVE ? open_all_pin : ~open_all_pin;
  // a counter, not a long repetition, measures the overlap against the latch time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovl_cnt <= '0;
    end else if ($countones(sel) == 2) begin
      ovl_cnt <= ovl_cnt + 1'b1;
    end else begin
      ovl_cnt <= '0;
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  property p_rst_idle;
    disable iff (1'b0) rst |-> sel == 6'h00 && !opn;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("drive active in reset");
  property p_pulse_len;
    $rose(|sel) |=> (|sel)[*7];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("drive pulse short");
  property p_open_len;
    $rose(opn) |=> opn[*7];
  endproperty
  a_open_len: assert property (p_open_len) else $error("open-all pulse short");
  property p_break_first;
    |(sel & ~$past(sel)) |-> $past(sel) == 6'h00;
  endproperty
  a_break_first: assert property (p_break_first) else $error("new drive on top of old");
  property p_open_alone;
    opn |-> sel == 6'h00 && $past(sel) == 6'h00;
  endproperty
  a_open_alone: assert property (p_open_alone) else $error("open-all with drive");
  // one idle cycle first, so the switch never sees two paths
  property p_select_drv;
    ce && cmd_valid && cmd_ready && cmd_op == RFSW_CMD_SELECT && cmd_path < 3'h6 && VMASK[cmd_path]
      |=> sel == 6'h00 ##1 sel == (6'h01 << $past(cmd_path, 2));
  endproperty
  a_select_drv: assert property (p_select_drv) else $error("wrong select drive");
  property p_mbb;
    $countones(sel) == 2 ##1 $countones(sel) != 2 |-> $countones(sel) == 1 && ovl_cnt >= LATCH_CYCLES;
  endproperty
  a_mbb: assert property (p_mbb) else $error("overlap not dropped to new path");
  property p_ready_idle;
    cmd_ready |-> sel == 6'h00 && !opn;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready while driving");
  c_sel: cover property ($rose(|sel));
  c_mbb: cover property ($countones(sel) == 2);
  c_open: cover property ($rose(opn));
endmodule : rfsw_ctrl_props

// *** rfsw_latch_tmr.sv ***
// rfsw_latch_tmr: counts the minimum solenoid drive time after each start
// assumes start is a one-cycle pulse from the controller
`timescale 1ns/1ns
module rfsw_latch_tmr
  import rfsw_pkg::*;
#(
  parameter int unsigned CYCLES = LATCH_CYC
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  // controller side
  rfsw_tmr_if.tmr   tmr
);

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             run;
    logic             expired;
  } rfsw_tmr_s;

  localparam logic [TMR_W-1:0] LAST = TMR_W'(CYCLES - 1);

  rfsw_tmr_s r;
  rfsw_tmr_s next_r;

  always_comb begin
    next_r         = r;
    next_r.expired = 1'b0;
    if (tmr.start) begin
      next_r.cnt = '0;
      next_r.run = 1'b1;
    end else if (r.run) begin
      if (r.cnt == LAST) begin
        next_r.run     = 1'b0;
        next_r.expired = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign tmr.expired = r.expired;

endmodule : rfsw_latch_tmr

// *** rfsw_pkg.sv ***
// rfsw_pkg: constants, states and state struct for the rf switch path controller
// assumes a 25 MHz system clock; shared by the controller and its pulse timer
package rfsw_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned LATCH_MS      = 15;
  localparam int unsigned LATCH_CYC     = (CLK_HZ / 1000) * LATCH_MS;
  localparam int unsigned TMR_W         = 20;

  // ----------------------------------------------------------------
  // path layout
  // ----------------------------------------------------------------
  localparam int unsigned NPATH         = 6;
  localparam int unsigned PATH_W        = 3;
  localparam logic [5:0]  FOUR_MASK     = 6'h36;  // positions 1 and 4 unused
  localparam logic [5:0]  SIX_MASK      = 6'h3f;
  localparam logic [5:0]  NO_PATHS      = 6'h00;
  localparam logic [5:0]  ONE_PATH      = 6'h01;
  localparam logic [2:0]  PATH_ZERO     = 3'h0;

  // ----------------------------------------------------------------
  // commands, controller states and state struct
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RFSW_CMD_SELECT,
    RFSW_CMD_MBB,
    RFSW_CMD_OPEN_ALL
  } rfsw_cmd_e;

  typedef enum {
    RFSW_IDLE,
    RFSW_RELEASE,
    RFSW_DRIVE,
    RFSW_OVERLAP,
    RFSW_DROP_OLD,
    RFSW_OPEN,
    RFSW_CHECK
  } rfsw_state_e;

  typedef struct packed {
    rfsw_state_e state;
    logic [5:0]  drive;
    logic        open_all;
    logic [5:0]  want;
    logic [5:0]  old_sel;
    logic        busy;
    logic        done;
    logic        fault;
    logic        tmr_go;
  } rfsw_s;

endpackage : rfsw_pkg

// *** rfsw_switch_model.sv ***
// rfsw_switch_model: latching multiport switch with position indicators
// assumes logic-level drive; stuck holds the mechanism still
`timescale 1ns/1ns
module rfsw_switch_model #(
  parameter int MOVE = 4,
  parameter bit SIX  = 1'b1
) (
  input wire logic       clk_sys,
  input wire logic [5:0] drive_pin,
  input wire logic       open_all_pin,
  input wire logic       stuck,
  output logic [5:0]     ind_closed
);
  logic [5:0] pos;
  int         cnt;
  initial begin
    pos = 6'h00;
    cnt = 0;
  end
  // position changes once a drive has been held for MOVE cycles; releasing all pins restarts the count
  always @(posedge clk_sys) begin
    if (drive_pin == 6'h00 && !open_all_pin) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
      if (cnt + 1 >= MOVE && !stuck) begin
        if (open_all_pin) pos <= 6'h00;
        else if ($countones(drive_pin) == 1) pos <= drive_pin;
        else pos <= pos | drive_pin;
      end
    end
  end
  assign ind_closed = pos & (SIX ? 6'h3f : 6'h36);
endmodule : rfsw_switch_model

// *** rfsw_tmr_if.sv ***
// rfsw_tmr_if: start/expiry signals between controller and its latch timer
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
interface rfsw_tmr_if;
  logic start;
  logic expired;
  modport ctl (output start, input expired);
  modport tmr (input start, output expired);
endinterface : rfsw_tmr_if

// *** testbench.sv ***
// testbench: controller driving the switch model
// assumes package, interface and design files compiled first
`timescale 1ns/1ns
module testbench;
  import rfsw_pkg::*;
  localparam int unsigned L = 8;
  logic       clk_sys, rst, cmd_valid, cmd_ready, cmd_done, cmd_fault, open_all_pin, stuck;
  logic       ce, use_gnd, rdy, dn, g_ready, g_done, g_fault, g_open;
  logic [5:0] g_drive, g_ind;
  rfsw_cmd_e  cmd_op;
  logic [2:0] cmd_path;
  logic [5:0] drive_pin, ind_closed;
  int         fail_count, n_compared, lat, n;
  rfsw_ctrl #(.LATCH_CYCLES(L)) dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .cmd_valid(cmd_valid && !use_gnd),
    .cmd_op(cmd_op), .cmd_path(cmd_path), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .cmd_fault(cmd_fault), .drive_pin(drive_pin), .open_all_pin(open_all_pin), .ind_closed(ind_closed));
  rfsw_switch_model u_sw (.clk_sys(clk_sys), .drive_pin(drive_pin), .open_all_pin(open_all_pin),
    .stuck(stuck), .ind_closed(ind_closed));
  // ground-drive, four-throw unit without open-all; the inverters stand for its pin wiring
  rfsw_ctrl #(.LATCH_CYCLES(L), .LOGIC_LEVEL_DRIVE(1'b0), .SIX_THROW_CONFIG(1'b0), .HAS_OPEN_ALL(1'b0)) dut_gnd (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .cmd_valid(cmd_valid && use_gnd), .cmd_op(cmd_op), .cmd_path(cmd_path),
    .cmd_ready(g_ready), .cmd_done(g_done), .cmd_fault(g_fault), .drive_pin(g_drive), .open_all_pin(g_open),
    .ind_closed(g_ind));
  rfsw_switch_model #(.SIX(1'b0)) u_sw_gnd (.clk_sys(clk_sys), .drive_pin(~g_drive), .open_all_pin(~g_open),
    .stuck(1'b0), .ind_closed(g_ind));
  assign rdy = use_gnd ? g_ready : cmd_ready;
  assign dn  = use_gnd ? g_done : cmd_done;
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (!ok) begin
      fail_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic results;
    $display("mismatches %0d, compares %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // called at a falling edge; holds the request until the edge that takes it
  task automatic cmd(input rfsw_cmd_e op, input logic [2:0] path);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_path = path;
    for (n = 0; rdy !== 1'b1 && n < 50; n++) @(negedge clk_sys);
    if (rdy !== 1'b1) begin
      chk(1'b0, "command never taken");
      results();
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (lat = 1; dn !== 1'b1 && lat < 200; lat++) @(negedge clk_sys);
    if (dn !== 1'b1) begin
      chk(1'b0, "command never finished");
      results();
    end
  endtask : cmd
  task automatic t_select;
    for (int k = 0; k < 6; k++) begin
      cmd(RFSW_CMD_SELECT, 3'(k));
      chk(lat >= L + 1, "select finished early");
      chk(cmd_fault === 1'b0 && ind_closed === (6'h01 << k), "select path");
    end
  endtask : t_select
  task automatic t_mbb;
    cmd(RFSW_CMD_SELECT, 3'h1);
    cmd(RFSW_CMD_MBB, 3'h4);
    chk(lat >= 2 * L, "overlap too short");
    chk(cmd_fault === 1'b0 && ind_closed === 6'h10, "overlap result");
  endtask : t_mbb
  task automatic t_open;
    cmd(RFSW_CMD_OPEN_ALL, 3'h0);
    chk(cmd_fault === 1'b0 && ind_closed === 6'h00, "open all");
  endtask : t_open
  task automatic t_bad;
    cmd(RFSW_CMD_SELECT, 3'h6);
    chk(cmd_fault === 1'b1 && lat <= 3, "bad path accepted");
    cmd(rfsw_cmd_e'(2'h3), 3'h0);
    chk(cmd_fault === 1'b1, "bad op accepted");
  endtask : t_bad
  // a jammed mechanism must be reported, then cleared by a good command
  task automatic t_stuck;
    stuck = 1'b1;
    cmd(RFSW_CMD_SELECT, 3'h2);
    chk(cmd_fault === 1'b1, "jam not reported");
    stuck = 1'b0;
    cmd(RFSW_CMD_SELECT, 3'h2);
    chk(cmd_fault === 1'b0 && ind_closed === 6'h04, "fault not cleared");
  endtask : t_stuck
  // enable low must freeze a running pulse; a reset in mid-pulse must idle the pins
  task automatic t_freeze;
    logic [5:0] held;
    cmd_valid = 1'b1;
    cmd_op = RFSW_CMD_SELECT;
    cmd_path = 3'h5;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    held = drive_pin;
    ce = 1'b0;
    repeat (20) @(negedge clk_sys);
    chk(held === 6'h20 && drive_pin === held && cmd_done === 1'b0, "enable low did not freeze");
    ce = 1'b1;
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(drive_pin === 6'h00 && open_all_pin === 1'b0 && cmd_ready === 1'b0, "mid-run reset");
    rst = 1'b0;
    @(negedge clk_sys);
    chk(cmd_ready === 1'b1 && drive_pin === 6'h00 && ind_closed === 6'h20, "after mid-run reset");
  endtask : t_freeze
  task automatic t_ground;
    use_gnd = 1'b1;
    chk(g_drive === 6'h3f && g_open === 1'b1 && g_ready === 1'b1, "ground-drive idle level");
    cmd(RFSW_CMD_SELECT, 3'h1);
    chk(g_fault === 1'b0 && g_ind === 6'h02 && g_drive === 6'h3f, "ground-drive select");
    cmd(RFSW_CMD_SELECT, 3'h3);
    chk(g_fault === 1'b1 && lat <= 3 && g_ind === 6'h02, "unused four-throw path taken");
    cmd(RFSW_CMD_OPEN_ALL, 3'h0);
    chk(g_fault === 1'b1 && g_ind === 6'h02 && g_open === 1'b1, "open-all without the feature");
    use_gnd = 1'b0;
  endtask : t_ground
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    use_gnd = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = RFSW_CMD_SELECT;
    cmd_path = 3'h0;
    stuck = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk(drive_pin === 6'h00 && open_all_pin === 1'b0 && cmd_ready === 1'b1, "reset state");
    t_select();
    t_freeze();
    t_mbb();
    t_open();
    t_bad();
    t_stuck();
    t_ground();
    results();
  end
endmodule : testbench
bind rfsw_ctrl rfsw_ctrl_props #(.LATCH_CYCLES(LATCH_CYCLES), .LOGIC_LEVEL_DRIVE(LOGIC_LEVEL_DRIVE),
  .SIX_THROW_CONFIG(SIX_THROW_CONFIG)) u_props (.clk_sys(clk_sys), .rst(rst),
  .ce(ce), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_path(cmd_path), .cmd_ready(cmd_ready),
  .drive_pin(drive_pin), .open_all_pin(open_all_pin));
